// *** src/art_timer.sv ***
// PWM auto-reload timer with APB register access
`include "art_timer_map.svh"

// Summary of operation
// - Prescaler divides input by two to the power of the three-bit select.
// - External clock select picks CPU clock or external event input.
// - Run enable clear freezes counter and prescaler; set lets counter advance.
// - Reset clears counter and prescaler and selects the CPU clock.
// - Force reload with run, or counter write, loads counter and clears prescaler.
// - Prescaler is never visible to software.
// - Four compare shadows load from duty registers only at overflow.
// - Output enable bit drives the channel pin as push-pull PWM.
// - All channels share a frequency of tick rate over 256 minus reload.
// - Overflow sets pin to inverse of polarity bit; compare match restores polarity level.
// - Full resolution needs reload zero; 0% and 100% come from polarity.
// - PWM generation stops during halt mode.
// - Overflow sets flag and requests interrupt when enabled; software clears.
// - Externally clocked, flag sets after 256 minus reload events.
// - Halt with external clock freezes registers but counter keeps counting.
// - Selected capture edge latches counter and sets capture flag.
// - Edge select chooses polarity; interrupt enable gates each capture request.
// - Capture register not updated again until software reads it.
// - Capture interrupt holds while flag and enable are both set.
// - In halt an enabled capture edge wakes the microcontroller.
// - Counter increments per tick and reloads at overflow, prescaler untouched.
// - Reading control/status clears the overflow flag.
// - Force reload bit is write-only and reads as zero.
// - A polarity write inverts the channel output at once.
module art_timer import art_timer_pkg::*; (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic haltMode,
  input wire logic externalEventClock,
  input wire logic [1:0] captureInputPin,
  output logic [3:0] pulseOutputPin,
  output logic [3:0] pulseOutputEnN,
  output logic overflowIrq,
  output logic [1:0] captureIrq,
  output logic wakeRequest
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  art_state_t st;
  art_state_t next_st;
  logic tick;
  logic prescClear;
  logic prescEnable;
  logic busWrite;
  logic busRead;
  logic busSetup;
  logic overflowNow;
  logic [7:0] counterPlus;
  logic [1:0] captureFlag;
  logic [1:0] captureRead;
  logic [7:0] captureValue1;
  logic [7:0] captureValue2;

  // Address match helper
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  // Register decode, unmapped addresses answer with an error
  function automatic logic mapped(input logic [7:0] addr);
    return (addr[1:0] == 2'b00) && (addr <= `ART_CAP2_ADDR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase decode

  // Zero-wait slave, registers frozen while halted
  assign busSetup = psel & ~penable;
  assign busWrite = psel & penable & pwrite & ~haltMode;
  assign busRead = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign prdata = st.readData;

  // Capture register reads clear the matching flag
  assign captureRead[0] = busRead & hit(paddr, `ART_CAP1_ADDR);
  assign captureRead[1] = busRead & hit(paddr, `ART_CAP2_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and capture channels

  // Counting continues in halt only on the external clock
  assign prescEnable = st.counterRunEnable & (~haltMode | st.extClockSelect);
  // Both software counter load paths restart the prescaler
  assign prescClear = busWrite & (hit(paddr, `ART_COUNTER_ADDR) |
                      (hit(paddr, `ART_CSR_ADDR) & pwdata[`ART_CSR_FORCE] & pwdata[`ART_CSR_RUN]));

  art_prescaler prescaler (
    .clock(clock),
    .nrst(nrst),
    .enable(prescEnable),
    .clear(prescClear),
    .extSelect(st.extClockSelect),
    .eventIn(externalEventClock),
    .divSelect(st.prescaleSelect),
    .tick(tick)
  );

  art_capture capture1 (
    .clock(clock),
    .nrst(nrst),
    .capturePin(captureInputPin[0]),
    .risingEdge(st.captureEdgeSelect[0]),
    .irqEnable(st.captureIrqEnable[0]),
    .counterValue(st.counter),
    .readAck(captureRead[0]),
    .captureFlag(captureFlag[0]),
    .captureValue(captureValue1),
    .captureIrq(captureIrq[0])
  );

  art_capture capture2 (
    .clock(clock),
    .nrst(nrst),
    .capturePin(captureInputPin[1]),
    .risingEdge(st.captureEdgeSelect[1]),
    .irqEnable(st.captureIrqEnable[1]),
    .counterValue(st.counter),
    .readAck(captureRead[1]),
    .captureFlag(captureFlag[1]),
    .captureValue(captureValue2),
    .captureIrq(captureIrq[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  assign overflowNow = tick && (st.counter == `ART_COUNTER_TOP);
  assign counterPlus = st.counter + 8'h01;

  always_comb begin
    next_st = st;

    // Read data captured in the setup cycle, held through access
    if (busSetup) begin
      next_st.readData = 32'h0000_0000;
      case (paddr)
        `ART_CSR_ADDR: begin
          next_st.readData[7:0] = {st.extClockSelect, st.prescaleSelect, st.counterRunEnable,
                                   1'b0, st.overflowIrqEnable, st.overflowFlag};
        end
        `ART_COUNTER_ADDR: begin
          next_st.readData[7:0] = st.counter;
        end
        `ART_RELOAD_ADDR: begin
          next_st.readData[7:0] = st.reload;
        end
        `ART_OUTCTRL_ADDR: begin
          next_st.readData[7:0] = st.outCtrl;
        end
        `ART_CAPCTRL_ADDR: begin
          next_st.readData[7:0] = {2'b00, st.captureEdgeSelect, st.captureIrqEnable, captureFlag};
        end
        `ART_CAP1_ADDR: begin
          next_st.readData[7:0] = captureValue1;
        end
        `ART_CAP2_ADDR: begin
          next_st.readData[7:0] = captureValue2;
        end
        default: begin
          if (mapped(paddr) && paddr >= `ART_DUTY0_ADDR && paddr <= `ART_DUTY3_ADDR) begin
            next_st.readData[7:0] = st.duty[paddr[3:2]];
          end
        end
      endcase
    end

    // Reading control/status clears the overflow flag
    if (busRead && hit(paddr, `ART_CSR_ADDR)) begin
      next_st.overflowFlag = 1'b0;
    end

    // Counting, overflow reload and compare match
    if (tick) begin
      if (overflowNow) begin
        next_st.counter = st.reload;
        next_st.overflowFlag = 1'b1;
        if (!haltMode) begin
          next_st.shadow = st.duty;
          next_st.activePhase = 4'hF;
        end
      end else begin
        next_st.counter = counterPlus;
        if (!haltMode) begin
          for (int i = 0; i < 4; i++) begin
            if (counterPlus == st.shadow[i]) begin
              next_st.activePhase[i] = 1'b0;
            end
          end
        end
      end
    end

    // Software writes
    if (busWrite) begin
      case (paddr)
        `ART_CSR_ADDR: begin
          next_st.extClockSelect = pwdata[`ART_CSR_EXTSEL];
          next_st.prescaleSelect = pwdata[`ART_CSR_PRESC_HI:`ART_CSR_PRESC_LO];
          next_st.counterRunEnable = pwdata[`ART_CSR_RUN];
          next_st.overflowIrqEnable = pwdata[`ART_CSR_OIE];
          if (pwdata[`ART_CSR_FORCE] && pwdata[`ART_CSR_RUN]) begin
            next_st.counter = st.reload;
          end
        end
        `ART_COUNTER_ADDR: begin
          next_st.counter = pwdata[7:0];
        end
        `ART_RELOAD_ADDR: begin
          next_st.reload = pwdata[7:0];
        end
        `ART_OUTCTRL_ADDR: begin
          next_st.outCtrl = pwdata[7:0];
        end
        `ART_CAPCTRL_ADDR: begin
          next_st.captureEdgeSelect = pwdata[5:4];
          next_st.captureIrqEnable = pwdata[3:2];
        end
        default: begin
          if (mapped(paddr) && paddr >= `ART_DUTY0_ADDR && paddr <= `ART_DUTY3_ADDR) begin
            next_st.duty[paddr[3:2]] = pwdata[7:0];
          end
        end
      endcase
    end

    // Polarity applies on top of the phase, so a polarity write flips at once
    next_st.pinLevel = next_st.activePhase ^ next_st.outCtrl[3:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and interrupt requests

  // Enabled channels drive their pin, output enable is active low
  assign pulseOutputPin = st.pinLevel;
  assign pulseOutputEnN = ~st.outCtrl[7:4];
  assign overflowIrq = st.overflowFlag & st.overflowIrqEnable;
  // Any pending request may end halt
  assign wakeRequest = overflowIrq | (|captureIrq);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  overflow_reload_a: assert property (overflowNow && !busWrite |=> st.counter == $past(st.reload) && st.overflowFlag)
    else $error("overflow did not reload counter");

  overflow_irq_a: assert property (overflowNow && st.overflowIrqEnable && !busWrite |=> overflowIrq)
    else $error("overflow interrupt missing");

  stopped_counter_a: assert property (!st.counterRunEnable && !busWrite |=> $stable(st.counter))
    else $error("counter moved while stopped");

  status_read_clear_a: assert property (busRead && hit(paddr, `ART_CSR_ADDR) && !overflowNow |=> !st.overflowFlag)
    else $error("overflow flag not cleared by read");

  force_reload_a: assert property (busWrite && hit(paddr, `ART_CSR_ADDR) && pwdata[2] && pwdata[3]
                                   |=> st.counter == $past(st.reload))
    else $error("force reload failed");

  shadow_stable_a: assert property (!overflowNow |=> $stable(st.shadow))
    else $error("shadow changed outside overflow");

  force_reads_zero_a: assert property (busSetup && hit(paddr, `ART_CSR_ADDR) |=> prdata[2] == 1'b0)
    else $error("force reload bit read back");

  polarity_flip_a: assert property (busWrite && hit(paddr, `ART_OUTCTRL_ADDR) && !tick
    |=> (pulseOutputPin ^ $past(pulseOutputPin)) == ($past(st.outCtrl[3:0]) ^ $past(pwdata[3:0])))
    else $error("pin level does not follow polarity");

  halt_pwm_frozen_a: assert property (haltMode |=> $stable(st.activePhase))
    else $error("PWM moved during halt");

  // Counter loads, steps and clock selection
  counter_load_a: assert property (busWrite && hit(paddr, `ART_COUNTER_ADDR)
                                   |=> st.counter == $past(pwdata[7:0]))
    else $error("counter write did not load");

  counter_step_a: assert property (tick && !overflowNow && !busWrite
                                   |=> st.counter == $past(st.counter) + 8'h01)
    else $error("counter did not advance on tick");

  clock_select_a: assert property (busWrite && hit(paddr, `ART_CSR_ADDR)
                                   |=> st.extClockSelect == $past(pwdata[`ART_CSR_EXTSEL])
                                       && st.prescaleSelect == $past(pwdata[`ART_CSR_PRESC_HI:`ART_CSR_PRESC_LO]))
    else $error("clock selection not taken");

  // Shadow load and phase restart at overflow, phase end at compare match
  shadow_load_a: assert property (overflowNow && !haltMode
                                  |=> st.shadow == $past(st.duty))
    else $error("shadow not loaded at overflow");

  phase_restart_a: assert property (overflowNow && !haltMode
                                    |=> st.activePhase == 4'hF)
    else $error("phases not restarted at overflow");

  compare_end_a: assert property (tick && !overflowNow && !haltMode && (st.counter + 8'h01) == st.shadow[0]
                                  |=> !st.activePhase[0])
    else $error("channel 0 phase did not end at match");

  // Halt freezes registers, stops CPU-clocked counting, keeps external counting
  halt_regs_frozen_a: assert property (haltMode
                                       |=> $stable(st.reload) && $stable(st.outCtrl) && $stable(st.duty))
    else $error("register changed during halt");

  halt_cpu_stop_a: assert property (haltMode && !st.extClockSelect
                                    |-> !tick)
    else $error("counter ticked in halt on CPU clock");

  halt_ext_count_a: assert property (haltMode && st.extClockSelect && tick && !overflowNow
                                     |=> st.counter == $past(st.counter) + 8'h01)
    else $error("external count stopped in halt");

endmodule

// *** src/art_timer_map.svh ***
// Register offsets, field positions and reset values of the auto-reload timer
`ifndef ART_TIMER_MAP_SVH
`define ART_TIMER_MAP_SVH

// Byte addresses on the register bus
`define ART_CSR_ADDR 8'h00
`define ART_COUNTER_ADDR 8'h04
`define ART_RELOAD_ADDR 8'h08
`define ART_OUTCTRL_ADDR 8'h0C
`define ART_DUTY0_ADDR 8'h10
`define ART_DUTY3_ADDR 8'h1C
`define ART_CAPCTRL_ADDR 8'h20
`define ART_CAP1_ADDR 8'h24
`define ART_CAP2_ADDR 8'h28

// Control/status field positions
`define ART_CSR_EXTSEL 7
`define ART_CSR_PRESC_HI 6
`define ART_CSR_PRESC_LO 4
`define ART_CSR_RUN 3
`define ART_CSR_FORCE 2
`define ART_CSR_OIE 1
`define ART_CSR_OVF 0

// Output control field positions
`define ART_OUT_ENABLE_LO 4
`define ART_OUT_POLARITY_LO 0

// Reset value and counter overflow top value
`define ART_RESET_BYTE 8'h00
`define ART_COUNTER_TOP 8'hFF

`endif

// *** src/art_timer_pkg.sv ***
// State types of the auto-reload timer and its helpers
package art_timer_pkg;

  // Main timer and register state
  typedef struct packed {
    logic [7:0] counter;
    logic [7:0] reload;
    logic [3:0][7:0] duty;
    logic [3:0][7:0] shadow;
    logic [7:0] outCtrl;
    logic extClockSelect;
    logic [2:0] prescaleSelect;
    logic counterRunEnable;
    logic overflowIrqEnable;
    logic overflowFlag;
    logic [1:0] captureEdgeSelect;
    logic [1:0] captureIrqEnable;
    logic [3:0] activePhase;
    logic [3:0] pinLevel;
    logic [31:0] readData;
  } art_state_t;

  // Prescaler state
  typedef struct packed {
    logic [6:0] count;
    logic eventPrev;
  } presc_state_t;

  // Capture channel state
  typedef struct packed {
    logic flag;
    logic [7:0] value;
    logic pinPrev;
  } capture_state_t;

endpackage

// *** src/art_prescaler.sv ***
// Seven-stage power-of-two prescaler with clock source selection
module art_prescaler import art_timer_pkg::*; (
  input wire logic clock,
  input wire logic nrst,
  input wire logic enable,
  input wire logic clear,
  input wire logic extSelect,
  input wire logic eventIn,
  input wire logic [2:0] divSelect,
  output logic tick
);

  presc_state_t st;
  presc_state_t next_st;
  logic inPulse;
  logic [6:0] mask;

  // Low bits that must all be set for a tap to fire
  function automatic logic [6:0] tapMask(input logic [2:0] sel);
    logic [7:0] full;
    full = (8'h01 << sel) - 8'h01;
    return full[6:0];
  endfunction

  // Input pulse select, count and tap decode
  always_comb begin
    next_st = st;
    tick = 1'b0;
    mask = tapMask(divSelect);
    inPulse = extSelect ? (eventIn & ~st.eventPrev) : 1'b1;
    next_st.eventPrev = eventIn;
    if (clear) begin
      next_st.count = 7'h00;
    end else if (enable && inPulse) begin
      tick = (st.count & mask) == mask;
      next_st.count = st.count + 7'h01;
    end
  end

  // State register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  tick_needs_run_a: assert property (!enable |-> !tick)
    else $error("prescaler ticked while stopped");
  clear_to_zero_a: assert property (clear |=> st.count == 7'h00)
    else $error("prescaler not cleared");
  frozen_count_a: assert property (!enable && !clear |=> $stable(st.count))
    else $error("prescaler moved while stopped");

endmodule

// *** src/art_capture.sv ***
// One input capture channel with read-to-clear flag
module art_capture import art_timer_pkg::*; (
  input wire logic clock,
  input wire logic nrst,
  input wire logic capturePin,
  input wire logic risingEdge,
  input wire logic irqEnable,
  input wire logic [7:0] counterValue,
  input wire logic readAck,
  output logic captureFlag,
  output logic [7:0] captureValue,
  output logic captureIrq
);

  capture_state_t st;
  capture_state_t next_st;
  logic edgeSeen;

  // Edge detect, latch and flag handling
  always_comb begin
    next_st = st;
    edgeSeen = risingEdge ? (capturePin & ~st.pinPrev) : (~capturePin & st.pinPrev);
    next_st.pinPrev = capturePin;
    if (readAck) begin
      next_st.flag = 1'b0;
    end
    // A new edge during the clearing read still lands
    if (edgeSeen && (!st.flag || readAck)) begin
      next_st.value = counterValue;
      next_st.flag = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign captureFlag = st.flag;
  assign captureValue = st.value;
  assign captureIrq = st.flag & irqEnable;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  capture_hold_a: assert property (st.flag && !readAck |=> $stable(st.value))
    else $error("capture value overwritten before read");
  capture_latch_a: assert property (edgeSeen && !st.flag |=> st.flag && st.value == $past(counterValue))
    else $error("capture did not latch counter");

endmodule

// *** bench/art_pins_model.sv ***
// Model of the external event input and the capture pins
module art_pins_model (
  input wire logic clock,
  output logic externalEventClock,
  output logic [1:0] captureInputPin
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle levels at time zero
  initial begin
    externalEventClock = 1'b0;
    captureInputPin = 2'b00;
  end

  // Event pulses, one clock high and one clock low each
  task automatic events(input int n);
    repeat (n) begin
      @(posedge clock) externalEventClock <= 1'b1;
      @(posedge clock) externalEventClock <= 1'b0;
    end
  endtask

  // Move one capture pin to a level
  task automatic setCap(input int ch, input logic lvl);
    @(posedge clock);
    captureInputPin[ch] <= lvl;
  endtask
endmodule

// *** bench/pwm_auto_reload_timer_test.sv ***
// Self-checking bench of the PWM auto-reload timer
`include "art_timer_map.svh"
module pwm_auto_reload_timer_test import art_timer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, nrst, psel, penable, pwrite, pready, pslverr, haltMode, externalEventClock;
  logic overflowIrq, wakeRequest, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, c1;
  logic [1:0] captureInputPin, captureIrq;
  logic [3:0] pulseOutputPin, pulseOutputEnN, p1;
  int fails, nCompared, h, l;

  art_timer i_art_timer (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .haltMode(haltMode), .externalEventClock(externalEventClock), .captureInputPin(captureInputPin),
    .pulseOutputPin(pulseOutputPin), .pulseOutputEnN(pulseOutputEnN), .overflowIrq(overflowIrq),
    .captureIrq(captureIrq), .wakeRequest(wakeRequest));
  art_pins_model i_art_pins_model (.clock(clock), .externalEventClock(externalEventClock),
    .captureInputPin(captureInputPin));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, verdict and comparison
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic timedOut;
    fails++;
    print_verdict();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // APB master: setup, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 20) timedOut();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check(name, rd, {24'h000000, exp});
  endtask

  // Wait at falling edges until channel 0 pin reaches a level, counting cycles
  task automatic waitPin(input logic lvl, output int n);
    n = 0;
    while (pulseOutputPin[0] !== lvl) begin
      @(negedge clock);
      n++;
      if (n > 5000) timedOut();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic scenReset;
    logic [7:0] addrs [7] = '{`ART_CSR_ADDR, `ART_COUNTER_ADDR, `ART_RELOAD_ADDR, `ART_OUTCTRL_ADDR,
      `ART_DUTY0_ADDR, `ART_CAPCTRL_ADDR, `ART_CAP1_ADDR};
    foreach (addrs[i]) rdchk("reset value", addrs[i], 8'h00);
    check("enable after reset", pulseOutputEnN, 4'hF);
    apb(1'b0, 8'h30, 8'h00);
    check("unmapped error", err, 1'b1);
    check("unmapped data", rd, 32'h00000000);
  endtask

  task automatic scenLoad;
    apb(1'b1, `ART_COUNTER_ADDR, 8'h10);
    repeat (20) @(posedge clock);
    rdchk("stopped counter", `ART_COUNTER_ADDR, 8'h10);
    apb(1'b1, `ART_RELOAD_ADDR, 8'hF0);
    apb(1'b1, `ART_CSR_ADDR, 8'h7C);
    rdchk("forced reload", `ART_COUNTER_ADDR, 8'hF0);
    rdchk("force reads zero", `ART_CSR_ADDR, 8'h78);
  endtask

  task automatic scenPwm;
    for (int i = 0; i < 4; i++) apb(1'b1, `ART_DUTY0_ADDR + 8'(4 * i), 8'hF8);
    apb(1'b1, `ART_OUTCTRL_ADDR, 8'h52);
    @(negedge clock);
    check("polarity at once", pulseOutputPin, 4'h2);
    check("drive enables", pulseOutputEnN, 4'hA);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, `ART_CSR_ADDR, {1'b0, 3'(s), 4'h8});
      waitPin(1'b0, h);
      waitPin(1'b1, h);
      waitPin(1'b0, h);
      waitPin(1'b1, l);
      check("pwm period", h + l, 16 << s);
      check("pwm high time", h, 8 << s);
      check("inverted channel", pulseOutputPin, 4'hD);
    end
    @(posedge clock) haltMode <= 1'b1;
    apb(1'b0, `ART_COUNTER_ADDR, 8'h00);
    c1 = rd;
    p1 = pulseOutputPin;
    repeat (300) @(posedge clock);
    rdchk("halted counter", `ART_COUNTER_ADDR, c1[7:0]);
    check("halted pins", pulseOutputPin, p1);
    @(posedge clock) haltMode <= 1'b0;
  endtask

  task automatic scenExternal;
    apb(1'b1, `ART_RELOAD_ADDR, 8'hFD);
    apb(1'b1, `ART_CSR_ADDR, 8'h8A);
    apb(1'b1, `ART_COUNTER_ADDR, 8'hFD);
    apb(1'b0, `ART_CSR_ADDR, 8'h00);
    @(posedge clock) haltMode <= 1'b1;
    i_art_pins_model.events(2);
    repeat (4) @(posedge clock);
    check("two events", overflowIrq, 1'b0);
    i_art_pins_model.events(1);
    repeat (4) @(posedge clock);
    check("three events", overflowIrq, 1'b1);
    check("overflow wake", wakeRequest, 1'b1);
    apb(1'b1, `ART_RELOAD_ADDR, 8'h11);
    @(posedge clock) haltMode <= 1'b0;
    rdchk("frozen reload", `ART_RELOAD_ADDR, 8'hFD);
    rdchk("reloaded counter", `ART_COUNTER_ADDR, 8'hFD);
    rdchk("flag set", `ART_CSR_ADDR, 8'h8B);
    rdchk("flag cleared", `ART_CSR_ADDR, 8'h8A);
    @(negedge clock);
    check("irq cleared", overflowIrq, 1'b0);
  endtask

  task automatic scenCapture;
    apb(1'b1, `ART_CSR_ADDR, 8'h00);
    apb(1'b1, `ART_COUNTER_ADDR, 8'h55);
    apb(1'b1, `ART_CAPCTRL_ADDR, 8'h3C);
    i_art_pins_model.setCap(0, 1'b1);
    repeat (3) @(posedge clock);
    check("rising capture irq", captureIrq, 2'b01);
    apb(1'b1, `ART_COUNTER_ADDR, 8'h66);
    i_art_pins_model.setCap(0, 1'b0);
    i_art_pins_model.setCap(0, 1'b1);
    repeat (3) @(posedge clock);
    rdchk("capture flag", `ART_CAPCTRL_ADDR, 8'h3D);
    rdchk("held capture", `ART_CAP1_ADDR, 8'h55);
    @(negedge clock);
    check("irq after read", captureIrq, 2'b00);
    apb(1'b1, `ART_CAPCTRL_ADDR, 8'h08);
    i_art_pins_model.setCap(0, 1'b0);
    i_art_pins_model.setCap(1, 1'b1);
    repeat (3) @(posedge clock);
    check("gated and wrong edge", captureIrq, 2'b00);
    rdchk("falling capture flag", `ART_CAPCTRL_ADDR, 8'h09);
    @(posedge clock) haltMode <= 1'b1;
    i_art_pins_model.setCap(1, 1'b0);
    repeat (3) @(posedge clock);
    check("falling capture irq", captureIrq, 2'b10);
    check("capture wake", wakeRequest, 1'b1);
    rdchk("second capture", `ART_CAP2_ADDR, 8'h66);
    rdchk("first recapture", `ART_CAP1_ADDR, 8'h66);
    @(posedge clock) haltMode <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    haltMode = 1'b0;
    fails = 0;
    nCompared = 0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    scenReset();
    scenLoad();
    scenPwm();
    scenExternal();
    scenCapture();
    print_verdict();
  end
endmodule
